//--- hdl/core_regs_pkg.sv
package core_regs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // widths
   localparam int WORD_W = 16;
   localparam int WIDE_W = 20;
   localparam int FLAG_W = 11;
   localparam int IDX_W = 5;
   localparam int APB_AW = 7;
   localparam int STORE_AW = 4;

   ////////////////////////////////////////////////////////////////////////////
   // register index; byte address is four times the index
   localparam logic [4:0] IDX_DATA0 = 5'h00;
   localparam logic [4:0] IDX_DATA1 = 5'h01;
   localparam logic [4:0] IDX_DATA2 = 5'h02;
   localparam logic [4:0] IDX_DATA3 = 5'h03;
   localparam logic [4:0] IDX_ADDR0 = 5'h04;
   localparam logic [4:0] IDX_ADDR1 = 5'h05;
   localparam logic [4:0] IDX_FRAME = 5'h06;
   localparam logic [4:0] IDX_VTAB = 5'h07;
   localparam logic [4:0] IDX_PC = 5'h08;
   localparam logic [4:0] IDX_USP = 5'h09;
   localparam logic [4:0] IDX_ISP = 5'h0A;
   localparam logic [4:0] IDX_STATIC = 5'h0B;
   localparam logic [4:0] IDX_FLAG = 5'h0C;
   localparam logic [4:0] IDX_SP_ACT = 5'h0D;
   localparam logic [4:0] IDX_DPAIR_LO = 5'h0E;
   localparam logic [4:0] IDX_DPAIR_HI = 5'h0F;
   localparam logic [4:0] IDX_APAIR = 5'h10;
   localparam logic [4:0] IDX_LAST = 5'h10;

   ////////////////////////////////////////////////////////////////////////////
   // flag register bit positions
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_DEBUG = 1;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_SIGN = 3;
   localparam int FLAG_BANK = 4;
   localparam int FLAG_OVFL = 5;
   localparam int FLAG_IRQ_EN = 6;
   localparam int FLAG_STACK_SEL = 7;
   localparam int FLAG_LEVEL_LSB = 8;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [19:0] RST_WIDE = 20'h00000;
   localparam logic [10:0] RST_FLAG = 11'h000;

   ////////////////////////////////////////////////////////////////////////////
   // core write size
   typedef enum logic [1:0] {
      SIZE_BYTE = 2'b00,
      SIZE_WORD = 2'b01,
      SIZE_LONG = 2'b11
   } op_size_t;

endpackage : core_regs_pkg

//--- hdl/bank_store.sv
`timescale 1ns/1ps
module bank_store #(
   parameter int W = 16,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // write ports
   input wire logic we_a,
   input wire logic [AW-1:0] waddr_a,
   input wire logic [1:0] wbe_a,
   input wire logic [W-1:0] wdata_a,
   input wire logic we_b,
   input wire logic [AW-1:0] waddr_b,
   input wire logic [1:0] wbe_b,
   input wire logic [W-1:0] wdata_b,
   // read ports, each returns {hi word, lo word}
   input wire logic [AW-1:0] rlo_0,
   input wire logic [AW-1:0] rhi_0,
   output logic [2*W-1:0] rdata_0,
   input wire logic [AW-1:0] rlo_1,
   input wire logic [AW-1:0] rhi_1,
   output logic [2*W-1:0] rdata_1
);
   localparam int DEPTH = 1 << AW;
   localparam int HB = W / 2;

   logic [W-1:0] mem [DEPTH];

   // port b wins on a same-word, same-byte collision
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            for (int b = 0; b < 2; b++) begin
               if (we_b && waddr_b == AW'(i) && wbe_b[b]) begin
                  mem[i][b*HB +: HB] <= wdata_b[b*HB +: HB];
               end else if (we_a && waddr_a == AW'(i) && wbe_a[b]) begin
                  mem[i][b*HB +: HB] <= wdata_a[b*HB +: HB];
               end
            end
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_0 <= '0;
         rdata_1 <= '0;
      end else begin
         rdata_0 <= {mem[rhi_0], mem[rlo_0]};
         rdata_1 <= {mem[rhi_1], mem[rlo_1]};
      end
   end

endmodule : bank_store

//--- hdl/cpu_core_register_set.sv
`timescale 1ns/1ps
// Function
// - four 16-bit data registers for operations
// - first two data registers split into bytes
// - third:first and fourth:second form 32-bit pairs
// - two address registers feed addressing and operations
// - second:first address registers form 32-bit pair
// - 16-bit frame base for relative addressing
// - 20-bit interrupt vector table base
// - 20-bit program counter, next instruction address
// - user/interrupt stack pointer chosen by flag
// - 16-bit static base for relative addressing
// - low reset input initialises core registers
// - bank flag selects data/address/frame bank
// - flag register is 11 bits of state
module cpu_core_register_set
   import core_regs_pkg::*;
#(
   parameter logic [19:0] PC_RESET = RST_WIDE
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // core write port
   input wire logic core_wr_en,
   input wire logic [IDX_W-1:0] core_wr_sel,
   input wire op_size_t core_wr_size,
   input wire logic core_wr_upper,
   input wire logic [31:0] core_wr_data,
   // core read port, one cycle latency
   input wire logic [IDX_W-1:0] core_rd_sel,
   output logic [31:0] core_rd_data,
   // program flow
   input wire logic pc_advance,
   input wire logic [2:0] pc_step,
   input wire logic pc_load,
   input wire logic [WIDE_W-1:0] pc_target,
   input wire logic flag_wr_en,
   input wire logic [FLAG_W-1:0] flag_wr_data,
   // addressing bases
   output logic [WIDE_W-1:0] program_counter,
   output logic [WIDE_W-1:0] vector_table_base,
   output logic [WORD_W-1:0] frame_base_reg,
   output logic [WORD_W-1:0] static_base_reg,
   output logic [WORD_W-1:0] stack_ptr,
   output logic [FLAG_W-1:0] flag_register,
   output logic bank_sel
);

   ////////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic in_store(input logic [IDX_W-1:0] idx);
      return idx <= IDX_ADDR1 || (idx >= IDX_DPAIR_LO && idx <= IDX_LAST);
   endfunction : in_store

   function automatic logic is_pair(input logic [IDX_W-1:0] idx);
      return idx >= IDX_DPAIR_LO && idx <= IDX_LAST;
   endfunction : is_pair

   function automatic logic [2:0] lo_word(input logic [IDX_W-1:0] idx);
      case (idx)
         IDX_DPAIR_LO: lo_word = IDX_DATA0[2:0];
         IDX_DPAIR_HI: lo_word = IDX_DATA1[2:0];
         IDX_APAIR: lo_word = IDX_ADDR0[2:0];
         default: lo_word = idx[2:0];
      endcase
   endfunction : lo_word

   function automatic logic [2:0] hi_word(input logic [IDX_W-1:0] idx);
      case (idx)
         IDX_DPAIR_LO: hi_word = IDX_DATA2[2:0];
         IDX_DPAIR_HI: hi_word = IDX_DATA3[2:0];
         IDX_APAIR: hi_word = IDX_ADDR1[2:0];
         default: hi_word = idx[2:0];
      endcase
   endfunction : hi_word

   // only the first two data registers take single bytes
   function automatic logic [1:0] half_mask(input logic [IDX_W-1:0] idx,
                                            input logic [1:0] strb);
      if (idx == IDX_DATA0 || idx == IDX_DATA1) begin
         half_mask = strb;
      end else begin
         half_mask = (|strb) ? 2'b11 : 2'b00;
      end
   endfunction : half_mask

   function automatic logic [31:0] store_view(input logic [IDX_W-1:0] idx,
                                              input logic [31:0] raw);
      store_view = is_pair(idx) ? raw : {16'h0000, raw[15:0]};
   endfunction : store_view

   ////////////////////////////////////////////////////////////////////////////
   // state

   logic [WIDE_W-1:0] vtab;
   logic [WIDE_W-1:0] pc;
   logic [WORD_W-1:0] user_stack_ptr;
   logic [WORD_W-1:0] interrupt_stack_ptr;
   logic [WORD_W-1:0] sbase;
   logic [WORD_W-1:0] fbase [2];
   logic [FLAG_W-1:0] flags;
   logic bank;
   logic use_isp;

   assign bank = flags[FLAG_BANK];
   assign use_isp = flags[FLAG_STACK_SEL];

   ////////////////////////////////////////////////////////////////////////////
   // apb decode

   logic [IDX_W-1:0] apb_idx;
   logic apb_hit;
   logic apb_access;
   logic apb_wr;

   assign apb_idx = paddr[APB_AW-1:2];
   assign apb_hit = paddr[1:0] == 2'b00 && apb_idx <= IDX_LAST;
   assign apb_access = psel && penable;
   // core writes take priority; apb write waits them out
   assign apb_wr = apb_access && pwrite && apb_hit && !core_wr_en;
   assign pready = !(apb_access && pwrite && core_wr_en);
   assign pslverr = apb_access && pready && !apb_hit;

   ////////////////////////////////////////////////////////////////////////////
   // write request merge

   logic wr_go;
   logic [IDX_W-1:0] wr_idx;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;

   always_comb begin
      wr_go = 1'b0;
      wr_idx = core_wr_sel;
      wr_data = core_wr_data;
      wr_strb = 4'h0;
      if (core_wr_en) begin
         wr_go = 1'b1;
         case (core_wr_size)
            SIZE_BYTE: begin
               wr_data = {16'h0000, core_wr_data[7:0], core_wr_data[7:0]};
               wr_strb = core_wr_upper ? 4'h2 : 4'h1;
            end
            SIZE_WORD: wr_strb = 4'h3;
            SIZE_LONG: wr_strb = 4'hF;
            default: wr_strb = 4'h0;
         endcase
      end else if (apb_wr) begin
         wr_go = 1'b1;
         wr_idx = apb_idx;
         wr_data = pwdata;
         wr_strb = pstrb;
      end
   end

   logic [1:0] lo_mask;
   logic [1:0] wide_lo;
   logic wr_lo_store;
   logic wr_hi_store;

   assign lo_mask = half_mask(wr_idx, wr_strb[1:0]);
   assign wide_lo = (|wr_strb[1:0]) ? 2'b11 : 2'b00;
   assign wr_lo_store = wr_go && in_store(wr_idx) && (|lo_mask);
   // each half of a pair is written only under its own strobes
   assign wr_hi_store = wr_go && is_pair(wr_idx) && (|wr_strb[3:2]);

   function automatic logic [19:0] merge_wide(input logic [19:0] old,
                                              input logic [31:0] d,
                                              input logic [3:0] s);
      merge_wide = old;
      if (|s[1:0]) begin
         merge_wide[15:0] = d[15:0];
      end
      if (s[2]) begin
         merge_wide[19:16] = d[19:16];
      end
   endfunction : merge_wide

   function automatic logic hits(input logic go, input logic [IDX_W-1:0] a,
                                 input logic [IDX_W-1:0] b, input logic [1:0] m);
      return go && a == b && (|m);
   endfunction : hits

   ////////////////////////////////////////////////////////////////////////////
   // banked data, address store

   logic [31:0] apb_raw;
   logic [31:0] core_raw;

   bank_store #(
      .W(WORD_W),
      .AW(STORE_AW)
   ) u_store (
      .clk(pclk),
      .rst_n(presetn),
      .we_a(wr_lo_store),
      .waddr_a({bank, lo_word(wr_idx)}),
      .wbe_a(lo_mask),
      .wdata_a(wr_data[15:0]),
      .we_b(wr_hi_store),
      .waddr_b({bank, hi_word(wr_idx)}),
      .wbe_b(2'b11),
      .wdata_b(wr_data[31:16]),
      .rlo_0({bank, lo_word(apb_idx)}),
      .rhi_0({bank, hi_word(apb_idx)}),
      .rdata_0(apb_raw),
      .rlo_1({bank, lo_word(core_rd_sel)}),
      .rhi_1({bank, hi_word(core_rd_sel)}),
      .rdata_1(core_raw)
   );

   ////////////////////////////////////////////////////////////////////////////
   // frame and static bases

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fbase[0] <= RST_WORD;
         fbase[1] <= RST_WORD;
      end else if (hits(wr_go, wr_idx, IDX_FRAME, wr_strb[1:0])) begin
         fbase[bank] <= wr_data[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sbase <= RST_WORD;
      end else if (hits(wr_go, wr_idx, IDX_STATIC, wr_strb[1:0])) begin
         sbase <= wr_data[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // vector table base

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vtab <= RST_WIDE;
      end else if (hits(wr_go, wr_idx, IDX_VTAB, wr_strb[2:1] | wide_lo)) begin
         vtab <= merge_wide(vtab, wr_data, wr_strb);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // program counter; register write beats load beats advance

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc <= PC_RESET;
      end else if (hits(wr_go, wr_idx, IDX_PC, wr_strb[2:1] | wide_lo)) begin
         pc <= merge_wide(pc, wr_data, wr_strb);
      end else if (pc_load) begin
         pc <= pc_target;
      end else if (pc_advance) begin
         pc <= pc + WIDE_W'(pc_step);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // stack pointers

   logic usp_wr;
   logic isp_wr;
   logic sp_act_wr;

   assign sp_act_wr = hits(wr_go, wr_idx, IDX_SP_ACT, wr_strb[1:0]);
   assign usp_wr = hits(wr_go, wr_idx, IDX_USP, wr_strb[1:0]) || (sp_act_wr && !use_isp);
   assign isp_wr = hits(wr_go, wr_idx, IDX_ISP, wr_strb[1:0]) || (sp_act_wr && use_isp);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         user_stack_ptr <= RST_WORD;
      end else if (usp_wr) begin
         user_stack_ptr <= wr_data[15:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         interrupt_stack_ptr <= RST_WORD;
      end else if (isp_wr) begin
         interrupt_stack_ptr <= wr_data[15:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // flag register; bus or indexed write beats the core flag port

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags <= RST_FLAG;
      end else if (hits(wr_go, wr_idx, IDX_FLAG, wr_strb[1:0])) begin
         flags <= wr_data[FLAG_W-1:0];
      end else if (flag_wr_en) begin
         flags <= flag_wr_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read views of the registers kept outside the store

   function automatic logic [31:0] side_view(input logic [IDX_W-1:0] idx,
                                             input logic [19:0] v_tab,
                                             input logic [19:0] v_pc,
                                             input logic [15:0] v_fb,
                                             input logic [15:0] v_usp,
                                             input logic [15:0] v_isp,
                                             input logic [15:0] v_sb,
                                             input logic [10:0] v_flg,
                                             input logic v_u);
      case (idx)
         IDX_FRAME: side_view = {16'h0000, v_fb};
         IDX_VTAB: side_view = {12'h000, v_tab};
         IDX_PC: side_view = {12'h000, v_pc};
         IDX_USP: side_view = {16'h0000, v_usp};
         IDX_ISP: side_view = {16'h0000, v_isp};
         IDX_STATIC: side_view = {16'h0000, v_sb};
         IDX_FLAG: side_view = {21'h000000, v_flg};
         IDX_SP_ACT: side_view = {16'h0000, v_u ? v_isp : v_usp};
         default: side_view = 32'h00000000;
      endcase
   endfunction : side_view

   ////////////////////////////////////////////////////////////////////////////
   // apb read data; store words were sampled at the setup edge

   always_comb begin
      prdata = 32'h00000000;
      if (apb_access && apb_hit && !pwrite) begin
         if (in_store(apb_idx)) begin
            prdata = store_view(apb_idx, apb_raw);
         end else begin
            prdata = side_view(apb_idx, vtab, pc, fbase[bank], user_stack_ptr, interrupt_stack_ptr, sbase,
                               flags, use_isp);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // core read port

   logic [IDX_W-1:0] core_sel_q;
   logic [31:0] core_side_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         core_sel_q <= IDX_DATA0;
         core_side_q <= 32'h00000000;
      end else begin
         core_sel_q <= core_rd_sel;
         core_side_q <= side_view(core_rd_sel, vtab, pc, fbase[bank], user_stack_ptr, interrupt_stack_ptr,
                                  sbase, flags, use_isp);
      end
   end

   // both halves flop together, so a pair reads coherently
   assign core_rd_data = in_store(core_sel_q) ? store_view(core_sel_q, core_raw)
                                              : core_side_q;

   ////////////////////////////////////////////////////////////////////////////
   // addressing base outputs

   assign program_counter = pc;
   assign vector_table_base = vtab;
   assign frame_base_reg = fbase[bank];
   assign static_base_reg = sbase;
   assign stack_ptr = use_isp ? interrupt_stack_ptr : user_stack_ptr;
   assign flag_register = flags;
   assign bank_sel = bank;

endmodule : cpu_core_register_set

//--- dv/cpu_core_register_set_properties.sv
`timescale 1ns/1ps
module cpu_core_register_set_properties
   import core_regs_pkg::*;
#(
   parameter logic [19:0] PC_RESET = RST_WIDE
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_AW-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // core side
   input wire logic core_wr_en,
   input wire logic [IDX_W-1:0] core_rd_sel,
   input wire logic [31:0] core_rd_data,
   input wire logic pc_advance,
   input wire logic [2:0] pc_step,
   input wire logic pc_load,
   input wire logic [WIDE_W-1:0] pc_target,
   input wire logic flag_wr_en,
   input wire logic [FLAG_W-1:0] flag_wr_data,
   // state outputs
   input wire logic [WIDE_W-1:0] program_counter,
   input wire logic [WORD_W-1:0] frame_base_reg,
   input wire logic [WORD_W-1:0] static_base_reg,
   input wire logic [WORD_W-1:0] stack_ptr,
   input wire logic [FLAG_W-1:0] flag_register,
   input wire logic bank_sel
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire logic quiet = !core_wr_en && !(psel && penable && pwrite);

   ////////////////////////////////////////////////////////////////////////////
   property p_stall_cause;
      psel && penable && !pready |-> pwrite && core_wr_en;
   endproperty
   a_stall_cause: assert property (p_stall_cause)
      else $error("stall w/o core write");
   property p_ready_free;
      psel && penable && !core_wr_en |-> pready;
   endproperty
   a_ready_free: assert property (p_ready_free)
      else $error("stall while core idle");
   property p_unmapped;
      psel && penable && (paddr[6:2] > 5'h10 || paddr[1:0] != 2'h0)
         |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped not refused");
   property p_bank;
      bank_sel == flag_register[FLAG_BANK];
   endproperty
   a_bank: assert property (p_bank)
      else $error("bank differs from flag");
   property p_flag_load;
      flag_wr_en && quiet |=> flag_register == $past(flag_wr_data);
   endproperty
   a_flag_load: assert property (p_flag_load)
      else $error("flag load lost");
   property p_pc_load;
      pc_load && quiet |=> program_counter == $past(pc_target);
   endproperty
   a_pc_load: assert property (p_pc_load)
      else $error("pc load lost");
   property p_pc_step;
      pc_advance && !pc_load && quiet
         |=> program_counter == $past(program_counter) + 20'($past(pc_step));
   endproperty
   a_pc_step: assert property (p_pc_step)
      else $error("pc step wrong");
   property p_pc_hold;
      !pc_advance && !pc_load && quiet |=> $stable(program_counter);
   endproperty
   a_pc_hold: assert property (p_pc_hold)
      else $error("pc moved");
   property p_rd_sp;
      core_rd_sel == IDX_SP_ACT |=> core_rd_data[15:0] == $past(stack_ptr);
   endproperty
   a_rd_sp: assert property (p_rd_sp)
      else $error("stack read wrong");
   property p_rd_bases;
      core_rd_sel == IDX_FRAME |=> core_rd_data[15:0] == $past(frame_base_reg);
   endproperty
   a_rd_bases: assert property (p_rd_bases)
      else $error("frame read wrong");
   property p_rd_static;
      core_rd_sel == IDX_STATIC |=> core_rd_data[15:0] == $past(static_base_reg);
   endproperty
   a_rd_static: assert property (p_rd_static)
      else $error("static read wrong");
   property p_reset;
      $rose(presetn) |-> program_counter == PC_RESET && flag_register == RST_FLAG
         && stack_ptr == RST_WORD && frame_base_reg == RST_WORD;
   endproperty
   a_reset: assert property (p_reset)
      else $error("reset not clean");
endmodule : cpu_core_register_set_properties

bind cpu_core_register_set cpu_core_register_set_properties #(.PC_RESET(PC_RESET)) u_props (.*);

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
   import core_regs_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [6:0] paddr = 7'h00;
   logic [31:0] pwdata = 32'h0, prdata, core_wr_data = 32'h0, core_rd_data;
   logic [3:0] pstrb = 4'h0;
   logic core_wr_en = 1'b0, core_wr_upper = 1'b0, pc_advance = 1'b0, pc_load = 1'b0;
   logic [4:0] core_wr_sel = 5'h00, core_rd_sel = 5'h00;
   op_size_t core_wr_size = SIZE_WORD;
   logic [2:0] pc_step = 3'h0;
   logic [19:0] pc_target = 20'h00000, program_counter, vector_table_base;
   logic flag_wr_en = 1'b0, bank_sel;
   logic [10:0] flag_wr_data = 11'h000, flag_register;
   logic [15:0] frame_base_reg, static_base_reg, stack_ptr;
   logic [31:0] seed = 32'h0000_0057;
   logic [31:0] m [0:12] = '{default: 32'h0};
   int err_total = 0, n_compared = 0, cyc = 0;

   cpu_core_register_set DUT (.*);

   always #5 pclk = ~pclk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : complete_run

   always @(posedge pclk) begin
      core_rd_sel <= (core_rd_sel >= 5'h10) ? 5'h00 : core_rd_sel + 5'h01;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         complete_run();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   function automatic logic [31:0] msk(input int i);
      case (i)
         7, 8: return 32'h000F_FFFF;
         12: return 32'h0000_07FF;
         14, 15, 16: return 32'hFFFF_FFFF;
         default: return 32'h0000_FFFF;
      endcase
   endfunction : msk

   task automatic chk(input logic ok, input string s);
      n_compared++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("ERROR %0t %s", $time, s);
      end
   endtask : chk

   ////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic w, input logic [6:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] r, output logic e);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge pclk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk(1'b0, "apb hang");
   endtask : apb

   task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      logic e;
      apb(1'b1, {i, 2'b00}, d, s, r, e);
   endtask : wr

   task automatic rchk(input logic [4:0] i, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, {i, 2'b00}, 32'h0, 4'h0, r, e);
      chk((r & msk(i)) === (x & msk(i)) && e === 1'b0, "read value");
   endtask : rchk

   task automatic core(input logic [4:0] sel, input op_size_t z, input logic up,
                       input logic [31:0] d, input int n);
      @(posedge pclk);
      core_wr_en <= 1'b1;
      core_wr_sel <= sel;
      core_wr_size <= z;
      core_wr_upper <= up;
      core_wr_data <= d;
      repeat (n) @(posedge pclk);
      core_wr_en <= 1'b0;
   endtask : core

   task automatic side(input logic fl, input logic [10:0] v, input logic ld,
                       input logic adv, input logic [2:0] s, input logic [19:0] t);
      @(posedge pclk);
      flag_wr_en <= fl;
      flag_wr_data <= v;
      pc_load <= ld;
      pc_advance <= adv;
      pc_step <= s;
      pc_target <= t;
      @(posedge pclk);
      flag_wr_en <= 1'b0;
      pc_load <= 1'b0;
      pc_advance <= 1'b0;
   endtask : side

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] r, d;
      logic [19:0] pe;
      logic e;
      int i, k;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i <= 16; i++) rchk(5'(i), 32'h0);
      for (i = 0; i < 30; i++) begin
         k = int'(rnd() % 12);
         d = rnd();
         wr(5'(k), d, 4'hF);
         m[k] = d & msk(k);
      end
      for (i = 0; i < 12; i++) rchk(5'(i), m[i]);
      chk(program_counter === m[8][19:0] && frame_base_reg === m[6][15:0], "pc");
      chk(vector_table_base === m[7][19:0] && static_base_reg === m[11][15:0], "sb");
      rchk(IDX_DPAIR_LO, {m[2][15:0], m[0][15:0]});
      rchk(IDX_APAIR, {m[5][15:0], m[4][15:0]});
      $display("test words done");
      for (i = 0; i < 2; i++) begin
         wr(IDX_FLAG, i ? 32'h0000_0080 : 32'h0, 4'hF);
         rchk(IDX_SP_ACT, m[9 + i]);
         d = rnd();
         wr(IDX_SP_ACT, d, 4'h3);
         m[9 + i] = d & 32'h0000_FFFF;
         rchk(5'(9 + i), m[9 + i]);
         chk(stack_ptr === m[9 + i][15:0] && flag_register[7] === 1'(i), "sp");
      end
      $display("test stack done");
      d = rnd();
      wr(IDX_DATA0, d, 4'h1);
      m[0][7:0] = d[7:0];
      wr(IDX_DATA1, d, 4'h2);
      m[1][15:8] = d[15:8];
      wr(IDX_DPAIR_LO, d, 4'hC);
      m[2] = {16'h0, d[31:16]};
      wr(IDX_APAIR, d, 4'h3);
      m[4] = {16'h0, d[15:0]};
      core(IDX_DATA0, SIZE_BYTE, 1'b1, d, 1);
      m[0][15:8] = d[7:0];
      core(IDX_DPAIR_HI, SIZE_LONG, 1'b0, d, 1);
      m[3] = {16'h0, d[31:16]};
      m[1] = {16'h0, d[15:0]};
      core(IDX_DATA1, SIZE_BYTE, 1'b0, ~d, 1);
      m[1][7:0] = ~d[7:0];
      core(IDX_STATIC, SIZE_WORD, 1'b0, ~d, 1);
      m[11] = {16'h0, ~d[15:0]};
      for (i = 0; i < 12; i++) rchk(5'(i), m[i]);
      $display("test halves done");
      fork
         wr(IDX_DATA3, d, 4'hF);
         core(IDX_DATA2, SIZE_WORD, 1'b0, ~d, 4);
      join
      m[3] = {16'h0, d[15:0]};
      m[2] = {16'h0, ~d[15:0]};
      rchk(IDX_DPAIR_LO, {m[2][15:0], m[0][15:0]});
      rchk(IDX_DPAIR_HI, {m[3][15:0], m[1][15:0]});
      $display("test collision done");
      side(1'b1, 11'h010, 1'b0, 1'b0, 3'h0, 20'h00000);
      rchk(IDX_DATA0, 32'h0);
      rchk(IDX_FLAG, 32'h0000_0010);
      wr(IDX_FRAME, d, 4'h3);
      @(negedge pclk);
      chk(bank_sel === 1'b1 && frame_base_reg === d[15:0], "bank one");
      side(1'b1, 11'h000, 1'b0, 1'b0, 3'h0, 20'h00000);
      rchk(IDX_FRAME, m[6]);
      rchk(IDX_DATA0, m[0]);
      $display("test bank done");
      pe = rnd();
      side(1'b0, 11'h000, 1'b1, 1'b0, 3'h0, pe);
      for (i = 0; i < 8; i++) begin
         side(1'b0, 11'h000, 1'b0, 1'b1, 3'(i), 20'h00000);
         pe += 20'(i);
      end
      @(negedge pclk);
      chk(program_counter === pe, "pc steps");
      side(1'b0, 11'h000, 1'b1, 1'b1, 3'h5, 20'hFFFFE);
      side(1'b0, 11'h000, 1'b0, 1'b1, 3'h3, 20'h00000);
      @(negedge pclk);
      chk(program_counter === 20'h00001, "pc wrap");
      $display("test pc done");
      apb(1'b0, 7'h44, 32'h0, 4'h0, r, e);
      chk(e === 1'b1 && r === 32'h0, "unmapped read");
      apb(1'b1, 7'h01, 32'hFFFF_FFFF, 4'hF, r, e);
      chk(e === 1'b1, "misaligned write");
      rchk(IDX_DATA0, m[0]);
      $display("test refusal done");
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i <= 16; i++) rchk(5'(i), 32'h0);
      $display("test second reset done");
      complete_run();
   end
endmodule : testbench
